// ---- iec_defs.svh ----
// register offsets, field positions, reset values and bus codes
// assumes a 32-bit axi4-lite slave with 5 address bits
`ifndef IEC_DEFS_SVH
`define IEC_DEFS_SVH

// ----------------------------------------
// address map
// ----------------------------------------
`define IEC_AW 5
`define IEC_OFF_MODE 5'h00
`define IEC_OFF_COUNT 5'h04
`define IEC_OFF_LATCH1 5'h08
`define IEC_OFF_LATCH2 5'h0c
`define IEC_OFF_STROBE 5'h10
`define IEC_OFF_STATUS 5'h14
`define IEC_OFF_MASK 5'h18
`define IEC_OFF_INPUTS 5'h1c

// ----------------------------------------
// mode register fields
// ----------------------------------------
`define IEC_MODE_W 8
`define IEC_MODE_RST 8'h04
`define IEC_M_DUAL 0
`define IEC_M_EVAL_HI 2
`define IEC_M_EVAL_LO 1
`define IEC_M_HYST 3
`define IEC_M_EXT1 4
`define IEC_M_EXT2 5
`define IEC_M_HOMEREF 6
`define IEC_M_REFEN 7

// ----------------------------------------
// status, mask, strobe and input fields
// ----------------------------------------
`define IEC_ST_W 4
`define IEC_ST_CAP1 0
`define IEC_ST_CAP2 1
`define IEC_ST_REF 2
`define IEC_ST_FAULT 3
`define IEC_ST_RST 4'h0
`define IEC_SB_LATCH1 0
`define IEC_SB_LATCH2 1
`define IEC_IN_HOME 0
`define IEC_IN_FAULT 1
`define IEC_IN_INDEX 2

// ----------------------------------------
// bus answers
// ----------------------------------------
`define IEC_RESP_OKAY 2'h0
`define IEC_RESP_SLVERR 2'h2
`define IEC_HALF 16

`endif

// ---- iec_pkg.sv ----
// types shared by the encoder counter files
// assumes iec_defs.svh for numeric constants
package iec_pkg;

    // edge evaluation selected by the mode register
    typedef enum logic [1:0] {
        IEC_EVAL_SINGLE = 2'h0,
        IEC_EVAL_DOUBLE = 2'h1,
        IEC_EVAL_QUAD = 2'h2
    } iec_eval_e;

endpackage : iec_pkg

// ---- iec_quad.sv ----
// one quadrature channel: two-stage sync, edge evaluation, direction
// assumes phase inputs are plain levels from the pins
`timescale 1ns/1ps
`include "iec_defs.svh"

module iec_quad import iec_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic in_a,
    input wire logic in_b,
    input wire iec_eval_e eval,
    output logic step,
    output logic up,
    output logic lvl_a,
    output logic lvl_b
);

    logic [1:0] meta;
    logic [1:0] sync;
    logic [1:0] prev;
    logic next_step;
    logic next_up;
    logic ea;
    logic eb;

    // ----------------------------------------
    // edge evaluation
    // ----------------------------------------
    always_comb begin
        ea = sync[1] ^ prev[1];
        eb = sync[0] ^ prev[0];
        next_step = 1'b0;
        next_up = 1'b0;
        case (eval) // [R4]
            IEC_EVAL_SINGLE: begin
                next_step = ea && !eb && sync[1];
                next_up = !sync[0]; // [R5]
            end
            IEC_EVAL_DOUBLE: begin
                next_step = ea && !eb;
                next_up = sync[1] ^ sync[0]; // [R5]
            end
            IEC_EVAL_QUAD: begin
                // both phases moving at once is a glitch, not a step
                next_step = ea ^ eb;
                next_up = ea ? (sync[1] ^ sync[0]) : !(sync[1] ^ sync[0]); // [R5]
            end
            default: begin
                next_step = 1'b0;
                next_up = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= 2'h0;
            sync <= 2'h0;
            prev <= 2'h0;
            step <= 1'b0;
            up <= 1'b0;
        end else begin
            meta <= {in_a, in_b}; // [R15]
            sync <= meta; // [R15]
            prev <= sync;
            step <= next_step;
            up <= next_up;
        end
    end

    assign lvl_a = sync[1];
    assign lvl_b = sync[0];

    property p_step_cause;
        @(posedge aclk) disable iff (!aresetn)
        step |-> $past(sync) != $past(prev);
    endproperty
    a_step_cause: assert property (p_step_cause) else $error("step without phase edge"); // [R4]

endmodule : iec_quad

// ---- iec_top.sv ----
// How it works
// [R1] mode bit selects one 32-bit channel or two independent 16-bit channels.
// [R2] in dual mode the third and fourth inputs are phases a and b of channel two.
// [R3] in single mode the third input is the reference marker and the fourth the fault input.
// [R4] single, double or quadruple edge evaluation is selected in the mode register.
// [R5] direction comes from the phase relation and the count goes up or down.
// [R6] with hysteresis on, the first step after a direction reversal is dropped.
// [R7] two 32-bit latches each take their strobe from software or from a pin.
// [R8] every strobe is synchronised to the clock before the count is captured.
// [R9] a capture comes from either trigger pin or from a write to the strobe register.
// [R10] a rising high level on trigger one fills latch one, trigger two fills latch two.
// [R11] a capture from either trigger pin sets a status bit that can raise the interrupt.
// [R12] the mode register is writable and readable over the bus.
// [R13] the home input reads through a register and may drive the reference logic.
// [R14] the reference marker clears the count when reference logic is enabled.
// [R15] all inputs pass two flip-flops before edge detection and counts wrap at their width.
// ----------------------------------------
// axi4-lite slave on aclk; encoder pins sampled on aclk
// ----------------------------------------
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "iec_defs.svh"

module iec_top import iec_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`IEC_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`IEC_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic enc_phase_a,
    input wire logic enc_phase_b,
    input wire logic enc_in_c,
    input wire logic enc_in_d,
    input wire logic home_in,
    input wire logic capture_trigger_first,
    input wire logic capture_trigger_second,
    output logic irq
);

    function automatic logic [31:0] count_step(input logic [31:0] v, input logic dir, input logic narrow);
        logic [31:0] r;
        r = dir ? v + 32'h1 : v - 32'h1;
        if (narrow) begin
            r[31:`IEC_HALF] = 16'h0;
        end
        return r;
    endfunction : count_step

    function automatic logic [`IEC_AW-1:0] word_of(input logic [`IEC_AW-1:0] a);
        return {a[`IEC_AW-1:2], 2'h0};
    endfunction : word_of

    // ----------------------------------------
    // channels and input sync
    // ----------------------------------------
    logic [`IEC_MODE_W-1:0] mode;
    logic dual;
    logic hyst;
    iec_eval_e eval;
    logic step0, up0, lvl_a, lvl_b;
    logic step1, up1, lvl_c, lvl_d;
    logic [2:0] in_meta, in_sync, in_prev;
    logic [1:0] capture_trigger_inputs;
    logic [1:0] trig_rise;
    logic encoder_fault_input;
    logic index_lvl, ref_lvl, ref_prev, fault_prev, ref_hit, fault_rise;

    assign dual = mode[`IEC_M_DUAL];
    assign hyst = mode[`IEC_M_HYST];
    assign eval = iec_eval_e'(mode[`IEC_M_EVAL_HI:`IEC_M_EVAL_LO]);

    iec_quad u_ch0 (
        .aclk(aclk), .aresetn(aresetn), .in_a(enc_phase_a), .in_b(enc_phase_b),
        .eval(eval), .step(step0), .up(up0), .lvl_a(lvl_a), .lvl_b(lvl_b)
    );
    // same sync serves index/fault in single mode and phases in dual mode
    iec_quad u_ch1 (
        .aclk(aclk), .aresetn(aresetn), .in_a(enc_in_c), .in_b(enc_in_d),
        .eval(eval), .step(step1), .up(up1), .lvl_a(lvl_c), .lvl_b(lvl_d)
    );

    assign capture_trigger_inputs = {capture_trigger_second, capture_trigger_first};
    assign trig_rise = in_sync[1:0] & ~in_prev[1:0];
    assign index_lvl = !dual && lvl_c; // [R3]
    assign encoder_fault_input = !dual && lvl_d; // [R3]
    // in dual mode the marker pin is a phase, so only home can reference
    assign ref_lvl = (mode[`IEC_M_HOMEREF] || dual) ? in_sync[2] : index_lvl; // [R13]
    assign ref_hit = mode[`IEC_M_REFEN] && ref_lvl && !ref_prev; // [R14]
    assign fault_rise = encoder_fault_input && !fault_prev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_meta <= 3'h0;
            in_sync <= 3'h0;
            in_prev <= 3'h0;
            ref_prev <= 1'b0;
            fault_prev <= 1'b0;
        end else begin
            in_meta <= {home_in, capture_trigger_inputs}; // [R8]
            in_sync <= in_meta; // [R8]
            in_prev <= in_sync;
            ref_prev <= ref_lvl;
            fault_prev <= encoder_fault_input;
        end
    end

    // ----------------------------------------
    // counters
    // ----------------------------------------
    logic [31:0] cnt0, next_cnt0, cnt1_wide, count_word;
    logic [15:0] cnt1, next_cnt1;
    logic dir0, dir1, next_dir0, next_dir1;

    assign cnt1_wide = count_step({16'h0, cnt1}, up1, 1'b1);
    assign count_word = dual ? {cnt1, cnt0[`IEC_HALF-1:0]} : cnt0; // [R1]

    always_comb begin
        next_cnt0 = cnt0;
        next_cnt1 = cnt1;
        next_dir0 = dir0;
        next_dir1 = dir1;
        if (step0) begin
            next_dir0 = up0;
            if (!(hyst && up0 != dir0)) begin // [R6]
                next_cnt0 = count_step(cnt0, up0, dual); // [R5] [R15]
            end
        end
        if (dual && step1) begin // [R2]
            next_dir1 = up1;
            if (!(hyst && up1 != dir1)) begin // [R6]
                next_cnt1 = cnt1_wide[`IEC_HALF-1:0]; // [R15]
            end
        end
        if (dual) begin
            next_cnt0[31:`IEC_HALF] = 16'h0; // [R1]
        end
        if (ref_hit) begin
            next_cnt0 = 32'h0; // [R14]
        end
    end

    // hysteresis assumes forward motion after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt0 <= 32'h0;
            cnt1 <= 16'h0;
            dir0 <= 1'b1;
            dir1 <= 1'b1;
        end else begin
            cnt0 <= next_cnt0;
            cnt1 <= next_cnt1;
            dir0 <= next_dir0;
            dir1 <= next_dir1;
        end
    end

    // ----------------------------------------
    // capture latches and status
    // ----------------------------------------
    logic [31:0] latch1, latch2, next_latch1, next_latch2;
    logic [1:0] sw_stb, ext_cap, stb;
    logic [`IEC_ST_W-1:0] status, mask, st_clr, next_status;
    logic wr_en, rd_en;
    logic [`IEC_AW-1:0] wr_addr;

    assign ext_cap = trig_rise & {mode[`IEC_M_EXT2], mode[`IEC_M_EXT1]}; // [R9] [R10]
    assign stb = ext_cap | (sw_stb & ~{mode[`IEC_M_EXT2], mode[`IEC_M_EXT1]}); // [R7] [R9]

    always_comb begin
        next_latch1 = stb[0] ? count_word : latch1; // [R7] [R10]
        next_latch2 = stb[1] ? count_word : latch2; // [R7] [R10]
        st_clr = '0;
        if (wr_en && wr_addr == `IEC_OFF_STATUS && s_axi_wstrb[0]) begin
            st_clr = s_axi_wdata[`IEC_ST_W-1:0];
        end
        // a new event wins over a clear in the same cycle
        next_status = status & ~st_clr;
        next_status[`IEC_ST_CAP1] = next_status[`IEC_ST_CAP1] | ext_cap[0]; // [R11]
        next_status[`IEC_ST_CAP2] = next_status[`IEC_ST_CAP2] | ext_cap[1]; // [R11]
        next_status[`IEC_ST_REF] = next_status[`IEC_ST_REF] | ref_hit;
        next_status[`IEC_ST_FAULT] = next_status[`IEC_ST_FAULT] | fault_rise; // [R3]
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch1 <= 32'h0;
            latch2 <= 32'h0;
            status <= `IEC_ST_RST;
            irq <= 1'b0;
        end else begin
            latch1 <= next_latch1;
            latch2 <= next_latch2;
            status <= next_status;
            irq <= |(status & mask); // [R11]
        end
    end

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    logic [`IEC_MODE_W-1:0] next_mode;
    logic [`IEC_ST_W-1:0] next_mask;
    logic [1:0] next_sw_stb, next_bresp, next_rresp;
    logic next_awready, next_bvalid, next_arready, next_rvalid;
    logic [31:0] next_rdata, rd_val;
    logic rd_ok, wr_ok;
    logic [`IEC_AW-1:0] rd_addr;

    // address and data are taken together, one write at a time
    assign wr_en = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
    assign rd_en = s_axi_arready && s_axi_arvalid;
    assign wr_addr = word_of(s_axi_awaddr);
    assign rd_addr = word_of(s_axi_araddr);

    always_comb begin
        rd_val = 32'h0;
        rd_ok = 1'b1;
        case (rd_addr)
            `IEC_OFF_MODE: rd_val[`IEC_MODE_W-1:0] = mode; // [R12]
            `IEC_OFF_COUNT: rd_val = count_word;
            `IEC_OFF_LATCH1: rd_val = latch1;
            `IEC_OFF_LATCH2: rd_val = latch2;
            `IEC_OFF_STROBE: rd_val = 32'h0;
            `IEC_OFF_STATUS: rd_val[`IEC_ST_W-1:0] = status;
            `IEC_OFF_MASK: rd_val[`IEC_ST_W-1:0] = mask;
            `IEC_OFF_INPUTS: begin
                rd_val[`IEC_IN_HOME] = in_sync[2]; // [R13]
                rd_val[`IEC_IN_FAULT] = encoder_fault_input;
                rd_val[`IEC_IN_INDEX] = index_lvl;
            end
            default: rd_ok = 1'b0;
        endcase
        wr_ok = wr_addr == `IEC_OFF_MODE || wr_addr == `IEC_OFF_STROBE
            || wr_addr == `IEC_OFF_STATUS || wr_addr == `IEC_OFF_MASK;
        next_mode = mode;
        next_mask = mask;
        next_sw_stb = 2'h0;
        if (wr_en && s_axi_wstrb[0]) begin
            case (wr_addr)
                `IEC_OFF_MODE: next_mode = s_axi_wdata[`IEC_MODE_W-1:0]; // [R12]
                `IEC_OFF_MASK: next_mask = s_axi_wdata[`IEC_ST_W-1:0];
                `IEC_OFF_STROBE: next_sw_stb = s_axi_wdata[`IEC_SB_LATCH2:`IEC_SB_LATCH1]; // [R9]
                default: next_mode = mode;
            endcase
        end
        next_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
        next_bvalid = s_axi_bvalid ? !s_axi_bready : wr_en;
        next_bresp = wr_en ? (wr_ok ? `IEC_RESP_OKAY : `IEC_RESP_SLVERR) : s_axi_bresp;
        next_arready = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
        next_rvalid = s_axi_rvalid ? !s_axi_rready : rd_en;
        next_rdata = rd_en ? rd_val : s_axi_rdata;
        next_rresp = rd_en ? (rd_ok ? `IEC_RESP_OKAY : `IEC_RESP_SLVERR) : s_axi_rresp;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= `IEC_MODE_RST;
            mask <= `IEC_ST_RST;
            sw_stb <= 2'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `IEC_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `IEC_RESP_OKAY;
        end else begin
            mode <= next_mode;
            mask <= next_mask;
            sw_stb <= next_sw_stb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_awready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_dual_held;
        dual ##1 dual;
    endsequence
    property p_dual_high_zero;
        @(posedge aclk) disable iff (!aresetn)
        s_dual_held |-> cnt0[31:`IEC_HALF] == 16'h0;
    endproperty
    a_dual_high_zero: assert property (p_dual_high_zero) else $error("upper half live in dual mode"); // [R1]

    property p_ch1_counts;
        @(posedge aclk) disable iff (!aresetn)
        (dual && step1 && !hyst) |=> cnt1 != $past(cnt1);
    endproperty
    a_ch1_counts: assert property (p_ch1_counts) else $error("second channel missed a step"); // [R2]

    property p_fault_flag;
        @(posedge aclk) disable iff (!aresetn)
        (!dual && lvl_d && !fault_prev) |=> status[`IEC_ST_FAULT];
    endproperty
    a_fault_flag: assert property (p_fault_flag) else $error("fault edge not flagged"); // [R3]

    property p_count_up;
        @(posedge aclk) disable iff (!aresetn)
        (!dual && step0 && up0 && !hyst && !ref_hit) |=> cnt0 == $past(cnt0) + 32'h1;
    endproperty
    a_count_up: assert property (p_count_up) else $error("up step not counted"); // [R5]

    property p_hyst_drop;
        @(posedge aclk) disable iff (!aresetn)
        (hyst && step0 && up0 != dir0 && !ref_hit && !dual) |=> cnt0 == $past(cnt0);
    endproperty
    a_hyst_drop: assert property (p_hyst_drop) else $error("reversal step not absorbed"); // [R6]

    property p_capture1;
        @(posedge aclk) disable iff (!aresetn)
        stb[0] |=> latch1 == $past(count_word);
    endproperty
    a_capture1: assert property (p_capture1) else $error("latch one missed the count"); // [R7]

    // watch the first sync stage, not the raw pin, so the check stays on our own flops
    sequence s_trig1_rise;
        !in_meta[0] ##1 in_meta[0];
    endsequence
    property p_trig_sync;
        @(posedge aclk) disable iff (!aresetn)
        s_trig1_rise |-> ##1 trig_rise[0];
    endproperty
    a_trig_sync: assert property (p_trig_sync) else $error("trigger edge not seen after sync"); // [R8]

    property p_irq_raise;
        @(posedge aclk) disable iff (!aresetn)
        (status[`IEC_ST_CAP1] && mask[`IEC_ST_CAP1]) |=> irq;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("masked-in capture gave no interrupt"); // [R11]

    property p_ref_clear;
        @(posedge aclk) disable iff (!aresetn)
        ref_hit |=> cnt0 == 32'h0 && status[`IEC_ST_REF];
    endproperty
    a_ref_clear: assert property (p_ref_clear) else $error("reference did not clear count"); // [R14]

endmodule : iec_top

// ---- iec_enc_model.sv ----
// encoder, reference switch and trigger pin model for the counter bench
// assumes its tasks are called right after a rising edge of aclk
`timescale 1ns/1ps

module iec_enc_model (
    input wire logic aclk,
    output logic pa,
    output logic pb,
    output logic pc,
    output logic pd,
    output logic home,
    output logic trig1,
    output logic trig2
);
    // cycles between phase changes; raise it for a slow encoder
    int gap = 3;

    initial {pa, pb, pc, pd, home, trig1, trig2} = 7'h0;

    // ----------------------------------------
    // one full period, one phase changing at a time
    // ----------------------------------------
    task turn(input int ch, input bit up);
        logic [7:0] seq;
        seq = up ? 8'hb4 : 8'h78;
        for (int i = 0; i < 4; i++) begin
            @(posedge aclk);
            if (ch == 1)
                {pa, pb} <= seq[7-2*i -: 2];
            else
                {pc, pd} <= seq[7-2*i -: 2];
            repeat (gap) @(posedge aclk);
        end
        repeat (6) @(posedge aclk);
    endtask : turn

    // levels stay put for six cycles, well past the synchroniser
    task level(input int which, input logic v);
        @(posedge aclk);
        case (which)
            0: pc <= v;
            1: pd <= v;
            2: home <= v;
            3: trig1 <= v;
            default: trig2 <= v;
        endcase
        repeat (6) @(posedge aclk);
    endtask : level

    task pulse(input int which);
        level(which, 1'h1);
        level(which, 1'h0);
    endtask : pulse
endmodule : iec_enc_model

// ---- tb.sv ----
// self-checking bench for the encoder counter
// assumes iec_top with its axi4-lite slave and the encoder model
`timescale 1ns/1ps
`include "iec_defs.svh"

module tb;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [`IEC_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, exp_cnt, rd_v;
    logic enc_phase_a, enc_phase_b, enc_in_c, enc_in_d, home_in;
    logic capture_trigger_first, capture_trigger_second;
    int n_fail = 0;
    int n_checks = 0;

    typedef struct {logic [7:0] mode; bit up; logic [31:0] delta;} iec_row_s;
    // eval codes 0..3 in both directions, hysteresis off
    iec_row_s rows[8] = '{'{8'h00, 1'h1, 32'h1}, '{8'h00, 1'h0, 32'hffffffff},
        '{8'h02, 1'h1, 32'h2}, '{8'h02, 1'h0, 32'hfffffffe}, '{8'h04, 1'h1, 32'h4},
        '{8'h04, 1'h0, 32'hfffffffc}, '{8'h06, 1'h1, 32'h0}, '{8'h06, 1'h0, 32'h0}};

    always #5 aclk = ~aclk;

    iec_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .enc_phase_a,
        .enc_phase_b, .enc_in_c, .enc_in_d, .home_in, .capture_trigger_first,
        .capture_trigger_second, .irq);

    iec_enc_model enc (.aclk(aclk), .pa(enc_phase_a), .pb(enc_phase_b), .pc(enc_in_c),
        .pd(enc_in_d), .home(home_in), .trig1(capture_trigger_first),
        .trig2(capture_trigger_second));

    // ----------------------------------------
    // bus tasks, entered right after a rising edge
    // ----------------------------------------
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task wr(input logic [4:0] a, input logic [31:0] d);
        logic aw_done;
        logic w_done;
        aw_done = 1'h0;
        w_done = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            aw_done = aw_done | (s_axi_awready === 1'h1);
            w_done = w_done | (s_axi_wready === 1'h1);
            s_axi_awvalid <= !aw_done;
            s_axi_wvalid <= !w_done;
        end
        s_axi_bready <= 1'h1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask : wr

    task rc(input string what, input logic [4:0] a, input logic [31:0] exp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
        rd_v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        chk(what, exp, rd_v);
        chk("rresp", `IEC_RESP_OKAY, {30'h0, resp});
    endtask : rc

    task move(input int ch, input bit up, input logic [31:0] delta);
        enc.turn(ch, up);
        exp_cnt = exp_cnt + delta;
        rc("count", `IEC_OFF_COUNT, exp_cnt);
    endtask : move

    task reset_dut();
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        exp_cnt = 32'h0;
    endtask : reset_dut

    task summarize();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        reset_dut();
        rc("mode", `IEC_OFF_MODE, 32'h04);
        rc("count", `IEC_OFF_COUNT, 32'h0);
        rc("status", `IEC_OFF_STATUS, 32'h0);
        rc("mask", `IEC_OFF_MASK, 32'h0);
        rc("strobe", `IEC_OFF_STROBE, 32'h0);
        wr(`IEC_OFF_MODE, 32'ha5);
        chk("bresp", `IEC_RESP_OKAY, resp);
        rc("mode", `IEC_OFF_MODE, 32'ha5);
        // count is read-only: the write is refused and changes nothing
        wr(`IEC_OFF_COUNT, 32'h55);
        chk("bresp", `IEC_RESP_SLVERR, resp);
        rc("count", `IEC_OFF_COUNT, 32'h0);
        $display("test reset done");
        // last direction after reset is up
        wr(`IEC_OFF_MODE, 32'h0c);
        move(1, 1'h1, 32'h4);
        move(1, 1'h0, 32'hfffffffd);
        move(1, 1'h0, 32'hfffffffc);
        move(1, 1'h1, 32'h3);
        $display("test hysteresis done");
        foreach (rows[i]) begin
            wr(`IEC_OFF_MODE, {24'h0, rows[i].mode});
            move(1, rows[i].up, rows[i].delta);
        end
        $display("test table done");
        wr(`IEC_OFF_MODE, 32'h34);
        wr(`IEC_OFF_MASK, 32'h3);
        move(1, 1'h1, 32'h4);
        enc.pulse(3);
        rc("latch1", `IEC_OFF_LATCH1, exp_cnt);
        rc("status", `IEC_OFF_STATUS, 32'h1);
        chk("irq", 32'h1, {31'h0, irq});
        wr(`IEC_OFF_STATUS, 32'h1);
        repeat (2) @(posedge aclk);
        chk("irq", 32'h0, {31'h0, irq});
        move(1, 1'h1, 32'h4);
        enc.pulse(4);
        rc("latch2", `IEC_OFF_LATCH2, exp_cnt);
        rc("latch1", `IEC_OFF_LATCH1, 32'h4);
        rc("status", `IEC_OFF_STATUS, 32'h2);
        wr(`IEC_OFF_STATUS, 32'h2);
        $display("test pin capture done");
        // latch1 stays on its pin, so the strobe only reaches latch2
        wr(`IEC_OFF_MODE, 32'h14);
        move(1, 1'h1, 32'h4);
        wr(`IEC_OFF_STROBE, 32'h3);
        repeat (4) @(posedge aclk);
        rc("latch1", `IEC_OFF_LATCH1, 32'h4);
        rc("latch2", `IEC_OFF_LATCH2, exp_cnt);
        rc("status", `IEC_OFF_STATUS, 32'h0);
        $display("test soft strobe done");
        wr(`IEC_OFF_MODE, 32'h84);
        enc.pulse(0);
        exp_cnt = 32'h0;
        rc("count", `IEC_OFF_COUNT, exp_cnt);
        rc("status", `IEC_OFF_STATUS, 32'h4);
        chk("irq", 32'h0, {31'h0, irq});
        wr(`IEC_OFF_STATUS, 32'h4);
        move(1, 1'h1, 32'h4);
        wr(`IEC_OFF_MODE, 32'hc4);
        enc.level(2, 1'h1);
        enc.level(1, 1'h1);
        rc("count", `IEC_OFF_COUNT, 32'h0);
        rc("inputs", `IEC_OFF_INPUTS, 32'h3);
        rc("status", `IEC_OFF_STATUS, 32'hc);
        enc.level(2, 1'h0);
        enc.level(1, 1'h0);
        wr(`IEC_OFF_STATUS, 32'hf);
        $display("test reference done");
        // second reset in mid-run, then two 16-bit channels
        reset_dut();
        wr(`IEC_OFF_MODE, 32'h05);
        enc.gap = 10;
        move(2, 1'h0, 32'hfffc0000);
        enc.gap = 3;
        move(1, 1'h1, 32'h4);
        move(1, 1'h0, 32'hfffffffc);
        move(1, 1'h0, 32'h0000fffc);
        $display("test dual done");
        summarize();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        summarize();
    end
endmodule : tb
